// ### shared/irq_ctrl_pkg.sv
// Purpose: constants and types shared by the interrupt controller files
// Assumes: one core clock, synchronous active-high reset
// Notes: source index 0..9 is also the fixed priority order, 0 highest
package irq_ctrl_pkg;

  // ****************************************
  // source map
  // ****************************************
  localparam int EXT_COUNT = 4;
  localparam int PERIPH_COUNT = 6;
  localparam int SRC_COUNT = 10;
  localparam logic [3:0] TRAP_INDEX = 4'hA;
  localparam logic [3:0] IDX_EXT0 = 4'h0;
  localparam logic [3:0] IDX_AVD = 4'h4;
  // exit from deep stop: ext0..3, autoreload overflow, small timer tick, spi
  localparam logic [9:0] STOP_WAKE_MASK = 10'h34F;
  // peripheral pending cleared by hardware on handler entry (supply warning)
  localparam logic [5:0] PERIPH_AUTO_CLEAR = 6'h01;

  // ****************************************
  // vectors, indexed by source, trap last
  // ****************************************
  localparam logic [15:0] VECTOR_TABLE [11] = '{
    16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFEC,
    16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFFC
  };

  // ****************************************
  // context stack
  // ****************************************
  localparam logic [2:0] CTX_DEPTH = 3'h5;
  localparam logic [2:0] CTX_FIRST = 3'h0;
  localparam logic [2:0] CTX_LAST = 3'h4;

  // ****************************************
  // external sensitivity codes
  // ****************************************
  localparam logic [1:0] SENSE_LOW_FALL = 2'h0;
  localparam logic [1:0] SENSE_RISE = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;
  localparam logic [7:0] SENSE_RESET = 8'h00;
  localparam logic PIN_IDLE_LEVEL = 1'h1;

  typedef enum logic [2:0] {
    s_run = 3'h1,
    s_save = 3'h2,
    s_restore = 3'h4
  } entry_state_t;

endpackage : irq_ctrl_pkg

// ### verilog/ext_source_latch.sv
// Purpose: one external interrupt source: sensitivity, latch, nand block
// Assumes: level and nand_low synchronous to clock
// Notes: pending is a flop; request is pending gated by the nand block
`timescale 1ns/1ns
module ext_source_latch (
  input wire logic clock,
  input wire logic reset,
  input wire logic level,
  input wire logic nand_low,
  input wire logic [1:0] sense,
  input wire logic taken,
  output logic pending,
  output logic request
);

  logic prev_level;
  logic next_prev_level;
  logic [1:0] prev_sense;
  logic [1:0] next_prev_sense;
  logic next_pending;
  logic hit;

  // ****************************************
  // edge and level detection
  // ****************************************
  always_comb begin
    next_prev_level = level;
    next_prev_sense = sense;
    case (sense)
      irq_ctrl_pkg::SENSE_LOW_FALL: hit = ~level;
      irq_ctrl_pkg::SENSE_RISE: hit = level & ~prev_level;
      irq_ctrl_pkg::SENSE_FALL: hit = ~level & prev_level;
      irq_ctrl_pkg::SENSE_BOTH: hit = level ^ prev_level;
      default: hit = 1'b0;
    endcase
    next_pending = pending;
    if (taken) begin
      next_pending = 1'b0; // R16
    end
    if (sense != prev_sense) begin
      next_pending = 1'b0; // R22
    end else if (hit) begin
      next_pending = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      prev_level <= irq_ctrl_pkg::PIN_IDLE_LEVEL;
      prev_sense <= irq_ctrl_pkg::SENSE_LOW_FALL;
      pending <= 1'b0;
    end else begin
      prev_level <= next_prev_level;
      prev_sense <= next_prev_sense;
      pending <= next_pending;
    end
  end

  // low on any enabled nanded pin masks the source
  assign request = pending & ~nand_low; // R17

  taken_clears_a: assert property (@(posedge clock) disable iff (reset) // R16
    (taken && !hit) |=> !pending) else $error("taken edge latch not cleared");
  sense_clears_a: assert property (@(posedge clock) disable iff (reset) // R22
    (sense != prev_sense) |=> !pending) else $error("sense change kept pending");
  nand_block_a: assert property (@(posedge clock) disable iff (reset) // R17
    nand_low |-> !request) else $error("nand low did not block request");

endmodule : ext_source_latch

// ### verilog/vectored_interrupt_controller.sv
// Purpose: latch, rank and dispatch interrupt requests to the core
// Assumes: core pulses core_boundary at each instruction end
// Notes: context push/pop is sequenced here, the core moves the bytes
// Functional notes
// R1: maskable requests are served only while the global mask is clear
// R2: after reset every source is disabled and the global mask is set
// R3: entry waits for the current instruction to finish
// R4: entry pushes program counter, index, accumulator and condition codes
// R5: entry sets the global mask
// R6: program counter is loaded from the winning source's vector
// R7: return restores context, clears the mask and resumes
// R8: a running handler is not preempted by maskable requests
// R9: fixed priority, higher vector address wins, spi lowest
// R10: any enabled source wakes the core from idle wait
// R11: only external, overflow, tick and spi sources wake from deep stop
// R12: software trap enters its own vector regardless of the mask
// R13: external vectors taken only if event occurred and mask clear
// R14: autoreload timer has compare and overflow vectors; only overflow stop-wakes
// R15: small timer has capture and tick vectors; only tick stop-wakes
// R16: edge-triggered external latch clears on handler entry
// R17: low on any enabled nanded pin blocks that external request
// R18: peripheral flag requests only when enabled and unmasked, else pends
// R19: software clears a peripheral request by writing zero or flag-access sequence
// R20: the clearing sequence resets the internal latch, dropping pending requests
// R21: interrupt context takes five stack locations
// R22: two-bit sensitivity per external source; changing it clears pending
// R23: requests sampled at each boundary, one winning vector per accept
`timescale 1ns/1ns
module vectored_interrupt_controller #(
  parameter int EXT_COUNT = irq_ctrl_pkg::EXT_COUNT,
  parameter int PERIPH_COUNT = irq_ctrl_pkg::PERIPH_COUNT
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] ext_level,
  input wire logic [3:0] ext_nand_low,
  input wire logic sense_write,
  input wire logic [7:0] sense_data,
  input wire logic [5:0] periph_flag,
  input wire logic [5:0] periph_enable,
  input wire logic [5:0] periph_clear,
  input wire logic core_boundary,
  input wire logic trap_exec,
  input wire logic return_exec,
  input wire logic mask_set_cmd,
  input wire logic mask_clear_cmd,
  input wire logic idle_mode,
  input wire logic stop_mode,
  output logic global_mask,
  output logic [7:0] ext_sense,
  output logic [3:0] ext_pending,
  output logic [5:0] periph_pending,
  output logic irq_accept,
  output logic stack_push,
  output logic stack_pop,
  output logic [2:0] stack_sel,
  output logic vector_load,
  output logic [15:0] vector_addr,
  output logic resume,
  output logic wake
);

  irq_ctrl_pkg::entry_state_t state;
  irq_ctrl_pkg::entry_state_t next_state;
  logic [2:0] ctx_count;
  logic [2:0] next_ctx_count;
  logic [3:0] winner;
  logic [3:0] next_winner;
  logic [3:0] pick;
  logic next_global_mask;
  logic [7:0] next_ext_sense;
  logic [5:0] next_periph_pending;
  logic next_irq_accept;
  logic next_stack_push;
  logic next_stack_pop;
  logic [2:0] next_stack_sel;
  logic next_vector_load;
  logic [15:0] next_vector_addr;
  logic next_resume;
  logic next_wake;
  logic [3:0] ext_take;
  logic [3:0] next_ext_take;
  logic [5:0] periph_take;
  logic [5:0] next_periph_take;
  logic [3:0] ext_request;
  logic [9:0] enabled_req;
  logic [9:0] active_req;
  logic accept_now;
  logic return_now;

  // ****************************************
  // external sources
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < EXT_COUNT; g++) begin : ext_src
      ext_source_latch ext_latch (
        .clock(clock),
        .reset(reset),
        .level(ext_level[g]),
        .nand_low(ext_nand_low[g]),
        .sense(ext_sense[2*g+1 -: 2]),
        .taken(ext_take[g]),
        .pending(ext_pending[g]),
        .request(ext_request[g])
      );
    end
  endgenerate

  // ****************************************
  // request ranking
  // ****************************************
  always_comb begin
    enabled_req = {periph_pending & periph_enable, ext_request}; // R18
    active_req = enabled_req & {10{~global_mask}}; // R1 R8 R13
    pick = irq_ctrl_pkg::TRAP_INDEX;
    // descending loop: lowest index, highest vector, wins
    for (int i = irq_ctrl_pkg::SRC_COUNT - 1; i >= 0; i--) begin
      if (active_req[i]) begin
        pick = 4'(i); // R9
      end
    end
    return_now = (state == irq_ctrl_pkg::s_run) && core_boundary && return_exec;
    // trap ignores the mask
    accept_now = (state == irq_ctrl_pkg::s_run) && core_boundary && !return_exec
      && (trap_exec || (|active_req)); // R3 R12 R23
  end

  // ****************************************
  // entry and return sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_ctx_count = ctx_count;
    next_winner = winner;
    next_global_mask = global_mask;
    next_irq_accept = 1'b0;
    next_stack_push = 1'b0;
    next_stack_pop = 1'b0;
    next_stack_sel = stack_sel;
    next_vector_load = 1'b0;
    next_vector_addr = vector_addr;
    next_resume = 1'b0;
    next_ext_take = '0;
    next_periph_take = '0;
    case (state)
      irq_ctrl_pkg::s_run: begin
        if (accept_now) begin
          next_state = irq_ctrl_pkg::s_save;
          next_winner = trap_exec ? irq_ctrl_pkg::TRAP_INDEX : pick; // R12
          next_global_mask = 1'b1; // R5
          next_irq_accept = 1'b1;
          next_stack_push = 1'b1; // R4
          next_stack_sel = irq_ctrl_pkg::CTX_FIRST;
          next_ctx_count = irq_ctrl_pkg::CTX_FIRST + 3'h1;
        end else if (return_now) begin
          next_state = irq_ctrl_pkg::s_restore;
          next_stack_pop = 1'b1; // R7
          next_stack_sel = irq_ctrl_pkg::CTX_LAST;
          next_ctx_count = irq_ctrl_pkg::CTX_FIRST + 3'h1;
        end else if (mask_set_cmd) begin
          next_global_mask = 1'b1;
        end else if (mask_clear_cmd) begin
          next_global_mask = 1'b0;
        end
      end
      irq_ctrl_pkg::s_save: begin
        if (ctx_count == irq_ctrl_pkg::CTX_DEPTH) begin
          next_state = irq_ctrl_pkg::s_run;
          next_vector_load = 1'b1;
          next_vector_addr = irq_ctrl_pkg::VECTOR_TABLE[winner]; // R6
          if (winner < irq_ctrl_pkg::IDX_AVD) begin
            next_ext_take[winner[1:0]] = 1'b1; // R16
          end else if (winner < irq_ctrl_pkg::TRAP_INDEX) begin
            next_periph_take = irq_ctrl_pkg::PERIPH_AUTO_CLEAR
              & (6'h01 << (winner - irq_ctrl_pkg::IDX_AVD));
          end
        end else begin
          next_stack_push = 1'b1; // R4 R21
          next_stack_sel = ctx_count;
          next_ctx_count = ctx_count + 3'h1;
        end
      end
      irq_ctrl_pkg::s_restore: begin
        if (ctx_count == irq_ctrl_pkg::CTX_DEPTH) begin
          next_state = irq_ctrl_pkg::s_run;
          next_global_mask = 1'b0; // R7
          next_resume = 1'b1;
        end else begin
          next_stack_pop = 1'b1; // R21
          next_stack_sel = irq_ctrl_pkg::CTX_LAST - ctx_count;
          next_ctx_count = ctx_count + 3'h1;
        end
      end
      default: begin
        next_state = irq_ctrl_pkg::s_run;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= irq_ctrl_pkg::s_run;
      ctx_count <= irq_ctrl_pkg::CTX_FIRST;
      winner <= irq_ctrl_pkg::TRAP_INDEX;
      global_mask <= 1'b1; // R2
      irq_accept <= 1'b0;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      stack_sel <= irq_ctrl_pkg::CTX_FIRST;
      vector_load <= 1'b0;
      vector_addr <= irq_ctrl_pkg::VECTOR_TABLE[irq_ctrl_pkg::TRAP_INDEX];
      resume <= 1'b0;
      ext_take <= '0;
      periph_take <= '0;
    end else begin
      state <= next_state;
      ctx_count <= next_ctx_count;
      winner <= next_winner;
      global_mask <= next_global_mask;
      irq_accept <= next_irq_accept;
      stack_push <= next_stack_push;
      stack_pop <= next_stack_pop;
      stack_sel <= next_stack_sel;
      vector_load <= next_vector_load;
      vector_addr <= next_vector_addr;
      resume <= next_resume;
      ext_take <= next_ext_take;
      periph_take <= next_periph_take;
    end
  end

  // ****************************************
  // peripheral latches, sensitivity, wake
  // ****************************************
  always_comb begin
    // flag keeps pending; set wins over clear
    next_periph_pending = (periph_pending & ~periph_clear & ~periph_take)
      | periph_flag; // R18 R20
    next_ext_sense = ext_sense;
    // sensitivity writable only while masked
    if (sense_write && global_mask) begin
      next_ext_sense = sense_data; // R22
    end
    next_wake = (idle_mode && (|enabled_req))
      || (stop_mode && (|(enabled_req & irq_ctrl_pkg::STOP_WAKE_MASK))); // R10 R11 R14 R15
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      periph_pending <= '0; // R2
      ext_sense <= irq_ctrl_pkg::SENSE_RESET;
      wake <= 1'b0;
    end else begin
      periph_pending <= next_periph_pending;
      ext_sense <= next_ext_sense;
      wake <= next_wake;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  mask_after_reset_a: assert property (@(posedge clock) // R2
    $fell(reset) |-> global_mask && !irq_accept) else $error("mask clear after reset");

  masked_no_accept_a: assert property (@(posedge clock) disable iff (reset) // R1
    (state == irq_ctrl_pkg::s_run && global_mask && !trap_exec && !mask_clear_cmd)
    |=> !irq_accept) else $error("maskable request accepted while masked");

  accept_boundary_a: assert property (@(posedge clock) disable iff (reset) // R3
    irq_accept |-> $past(core_boundary)) else $error("accept off instruction boundary");

  push_five_a: assert property (@(posedge clock) disable iff (reset) // R21
    irq_accept |-> global_mask && stack_push [*5] ##1 (!stack_push && vector_load))
    else $error("entry did not push five locations");

  pop_resume_a: assert property (@(posedge clock) disable iff (reset) // R7
    $rose(stack_pop) |-> stack_pop [*5] ##1 (resume && !global_mask))
    else $error("return did not restore and unmask");

  trap_vector_a: assert property (@(posedge clock) disable iff (reset) // R12
    (state == irq_ctrl_pkg::s_run && core_boundary && trap_exec && !return_exec)
    |=> ##5 (vector_load
    && vector_addr == irq_ctrl_pkg::VECTOR_TABLE[irq_ctrl_pkg::TRAP_INDEX]))
    else $error("trap vector not loaded");

  ext0_first_a: assert property (@(posedge clock) disable iff (reset) // R9
    (accept_now && !trap_exec && active_req[0])
    |=> ##5 (vector_addr == irq_ctrl_pkg::VECTOR_TABLE[irq_ctrl_pkg::IDX_EXT0]))
    else $error("highest priority source not chosen");

  no_preempt_a: assert property (@(posedge clock) disable iff (reset) // R8
    vector_load && !mask_clear_cmd && !trap_exec |=> !irq_accept)
    else $error("handler preempted");

  stop_wake_a: assert property (@(posedge clock) disable iff (reset) // R11
    (!idle_mode && ((enabled_req & irq_ctrl_pkg::STOP_WAKE_MASK) == '0)) |=> !wake)
    else $error("deep stop woken by non-waking source");

  idle_wake_a: assert property (@(posedge clock) disable iff (reset) // R10
    (idle_mode && (|enabled_req)) |=> wake) else $error("idle not woken");

endmodule : vectored_interrupt_controller

// ### dv/core_stack_model.sv
// Purpose: core-side context stack driven by the controller strobes
// Assumes: one context byte moves per strobe cycle
// Notes: bad_order counts slot order slips on push or pop
`timescale 1ns/1ns
module core_stack_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [2:0] stack_sel,
  output int depth,
  output int bad_order
);
  // ****************************************
  // context slots
  // ****************************************
  always @(posedge clock) begin
    if (reset) begin
      depth <= 0;
      bad_order <= 0;
    end else if (stack_push) begin
      if (stack_sel !== 3'(depth)) begin
        bad_order <= bad_order + 1;
      end
      depth <= depth + 1;
    end else if (stack_pop) begin
      if (stack_sel !== 3'(depth - 1)) begin
        bad_order <= bad_order + 1;
      end
      depth <= depth - 1;
    end
  end
endmodule : core_stack_model

// ### dv/vectored_interrupt_controller_bench.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: inputs change at the falling edge
// Notes: priority walk drains all ten sources one by one
`timescale 1ns/1ns
module vectored_interrupt_controller_bench;
  logic clock, reset, sense_write, core_boundary, trap_exec, return_exec;
  logic mask_set_cmd, mask_clear_cmd, idle_mode, stop_mode;
  logic [3:0] ext_level, ext_nand_low, ext_pending;
  logic [7:0] sense_data, ext_sense;
  logic [5:0] periph_flag, periph_enable, periph_clear, periph_pending;
  logic global_mask, irq_accept, stack_push, stack_pop, vector_load, resume, wake;
  logic [2:0] stack_sel;
  logic [15:0] vector_addr;
  int n_errors, compares, depth, bad_order, seed, k;
  int pend[$];
  logic [15:0] vec_tab [10] = '{16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFEC,
    16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2};

  vectored_interrupt_controller dut_u (.clock(clock), .reset(reset),
    .ext_level(ext_level), .ext_nand_low(ext_nand_low), .sense_write(sense_write),
    .sense_data(sense_data), .periph_flag(periph_flag), .periph_enable(periph_enable),
    .periph_clear(periph_clear), .core_boundary(core_boundary), .trap_exec(trap_exec),
    .return_exec(return_exec), .mask_set_cmd(mask_set_cmd),
    .mask_clear_cmd(mask_clear_cmd), .idle_mode(idle_mode), .stop_mode(stop_mode),
    .global_mask(global_mask), .ext_sense(ext_sense), .ext_pending(ext_pending),
    .periph_pending(periph_pending), .irq_accept(irq_accept), .stack_push(stack_push),
    .stack_pop(stack_pop), .stack_sel(stack_sel), .vector_load(vector_load),
    .vector_addr(vector_addr), .resume(resume), .wake(wake));

  core_stack_model stack_u (.clock(clock), .reset(reset), .stack_push(stack_push),
    .stack_pop(stack_pop), .stack_sel(stack_sel), .depth(depth), .bad_order(bad_order));

  always #2 clock = ~clock;

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task automatic bnd(input logic trap, input logic ret);
    @(negedge clock);
    core_boundary = 1'b1;
    trap_exec = trap;
    return_exec = ret;
    @(negedge clock);
    core_boundary = 1'b0;
    trap_exec = 1'b0;
    return_exec = 1'b0;
  endtask : bnd

  task automatic wait_for(input bit want_resume);
    int i;
    for (i = 0; i < 12; i++) begin
      @(posedge clock);
      #1;
      if ((want_resume ? resume : vector_load) === 1'b1) begin
        break;
      end
    end
    check(16'(i < 12), 16'h0001);
  endtask : wait_for

  task automatic enter(input logic trap, input logic [15:0] vec);
    bnd(trap, 1'b0);
    check(16'(irq_accept), 16'h0001);
    check(16'(global_mask), 16'h0001);
    wait_for(1'b0);
    check(vector_addr, vec);
    check(16'(depth), 16'h0005);
  endtask : enter

  task automatic leave();
    bnd(1'b0, 1'b0);
    check(16'(irq_accept), 16'h0000);
    bnd(1'b0, 1'b1);
    wait_for(1'b1);
    check(16'(global_mask), 16'h0000);
    check(16'(depth), 16'h0000);
  endtask : leave

  task automatic clear_periph(input logic [5:0] m);
    @(negedge clock);
    periph_clear = m;
    @(negedge clock);
    periph_clear = 6'h00;
  endtask : clear_periph

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    seed = 32'h10C5;
    {sense_write, core_boundary, trap_exec, return_exec} = 4'h0;
    {mask_set_cmd, mask_clear_cmd, idle_mode, stop_mode} = 4'h0;
    {ext_level, ext_nand_low, sense_data} = 16'hF000;
    {periph_flag, periph_enable, periph_clear} = 18'h00000;
    repeat (4) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    check(16'(global_mask), 16'h0001);
    check(vector_addr, 16'hFFFC);
    check(16'(ext_sense), 16'h0000);
    check(16'({ext_pending, periph_pending}), 16'h0000);
    sense_data = 8'hAA;
    sense_write = 1'b1;
    @(negedge clock);
    sense_write = 1'b0;
    periph_flag = 6'h3F;
    periph_enable = 6'h3F;
    @(negedge clock);
    periph_flag = 6'h00;
    // pins fall only after the sense change has settled
    ext_level = 4'h0;
    @(negedge clock);
    check(16'(ext_sense), 16'h00AA);
    check(16'({ext_pending, periph_pending}), 16'h03FF);
    enter(1'b1, 16'hFFFC);
    leave();
    for (k = 0; k < 10; k++) begin
      pend.push_back(k);
    end
    while (pend.size() > 0) begin
      k = pend.pop_front();
      @(negedge clock);
      // sensitivity write while unmasked must be refused
      sense_data = {1'b0, 7'($random(seed))};
      sense_write = 1'b1;
      @(negedge clock);
      sense_write = 1'b0;
      repeat ($unsigned($random(seed)) % 3) @(negedge clock);
      check(16'(ext_sense), 16'h00AA);
      enter(1'b0, vec_tab[k]);
      if (k >= 5) begin
        clear_periph(6'(1 << (k - 4)));
      end
      leave();
    end
    check(16'({ext_pending, periph_pending}), 16'h0000);
    @(negedge clock);
    ext_level = 4'hF;
    ext_nand_low = 4'h1;
    periph_enable = 6'h00;
    @(negedge clock);
    ext_level = 4'hE;
    periph_flag = 6'h20;
    repeat (2) @(negedge clock);
    periph_flag = 6'h00;
    check(16'(ext_pending), 16'h0001);
    bnd(1'b0, 1'b0);
    check(16'(irq_accept), 16'h0000);
    check(16'(periph_pending), 16'h0020);
    clear_periph(6'h20);
    check(16'(periph_pending), 16'h0000);
    mask_set_cmd = 1'b1;
    @(negedge clock);
    mask_set_cmd = 1'b0;
    sense_data = 8'hA9;
    sense_write = 1'b1;
    @(negedge clock);
    sense_write = 1'b0;
    ext_nand_low = 4'h0;
    @(negedge clock);
    check(16'(ext_pending), 16'h0000);
    periph_flag = 6'h01;
    periph_enable = 6'h01;
    stop_mode = 1'b1;
    repeat (3) @(negedge clock);
    check(16'(wake), 16'h0000);
    stop_mode = 1'b0;
    idle_mode = 1'b1;
    repeat (3) @(negedge clock);
    check(16'(wake), 16'h0001);
    idle_mode = 1'b0;
    stop_mode = 1'b1;
    periph_flag = 6'h04;
    periph_enable = 6'h05;
    repeat (3) @(negedge clock);
    check(16'(wake), 16'h0001);
    check(16'(bad_order), 16'h0000);
    complete_run();
  end

  initial begin
    #20000;
    n_errors++;
    complete_run();
  end
endmodule : vectored_interrupt_controller_bench
